// file: status_select_pkg.sv
package status_select_pkg;

	// ---------------------------------------------------------------
	// widths
	// ---------------------------------------------------------------
	localparam int PARCEL_W = 16;
	localparam int SPINDLES = 5;
	localparam int SEL_W = 16;
	localparam int TAG_LIVE_W = 6;

	// ---------------------------------------------------------------
	// selector codes (accumulator value)
	// ---------------------------------------------------------------
	localparam logic [SEL_W-1:0] SEL_XFER_COUNT = 16'h0002;
	localparam logic [SEL_W-1:0] SEL_TAG = 16'h0003;
	localparam logic [SEL_W-1:0] SEL_BUSY = 16'h0004;
	localparam logic [SEL_W-1:0] SEL_DONE = 16'h0005;
	localparam logic [SEL_W-1:0] SEL_ACK_PEND = 16'h0006;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int TAG_BUS_A_BIT = 6;
	localparam int TAG_BUS_B_BIT = 7;

	localparam logic [PARCEL_W-1:0] PARCEL_ZERO = 16'h0000;

	// ---------------------------------------------------------------
	// live interface tag lines, bit order of the tag parcel
	// ---------------------------------------------------------------
	typedef struct packed {
		logic attention_in;
		logic sync_out;
		logic sync_in;
		logic master_out;
		logic slave_in;
		logic select_out;
	} tag_lines_t;

	// ---------------------------------------------------------------
	// status sources watched by the readback
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [PARCEL_W-1:0] transfer_count;
		tag_lines_t tags;
		logic gate_bus_a;
		logic gate_bus_b;
		logic [SPINDLES-1:0] spindle_busy;
		logic [SPINDLES-1:0] spindle_done;
		logic [SPINDLES-1:0] dma_ack_pending;
	} status_src_t;

endpackage

// file: spindle_parcel.sv
`timescale 1ns/1ps
// zero-extends a per-spindle flag vector into a full parcel
module spindle_parcel
	import status_select_pkg::*;
(
	input wire logic [SPINDLES-1:0] flags,
	output logic [PARCEL_W-1:0] parcel
);

	always_comb begin
		parcel = PARCEL_ZERO;
		parcel[SPINDLES-1:0] = flags;
	end

endmodule

// file: status_select_readback.sv
`timescale 1ns/1ps
module status_select_readback
	import status_select_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic status_read_function,
	input wire logic [status_select_pkg::SEL_W-1:0] select_value,
	input wire status_select_pkg::status_src_t src,
	output logic [status_select_pkg::PARCEL_W-1:0] status_parcel,
	output logic status_valid,
	output logic select_known
);
	import status_select_pkg::*;

	// ---------------------------------------------------------------
	// selector kinds
	// ---------------------------------------------------------------
	// one kind per known selector, plus a catch-all for the rest
	typedef enum {
		KIND_NONE,
		KIND_XFER_COUNT,
		KIND_TAG,
		KIND_BUSY,
		KIND_DONE,
		KIND_ACK_PEND
	} sel_kind_t;

	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic [PARCEL_W-1:0] count_parcel;
	logic [PARCEL_W-1:0] tag_parcel;
	logic [PARCEL_W-1:0] busy_parcel;
	logic [PARCEL_W-1:0] done_parcel;
	logic [PARCEL_W-1:0] pend_parcel;
	sel_kind_t kind_nxt;
	logic [PARCEL_W-1:0] parcel_nxt;
	logic known_nxt;
	logic valid_nxt;
	logic [PARCEL_W-1:0] parcel_r;
	logic known_r;
	logic valid_r;

	// ---------------------------------------------------------------
	// selector decode functions
	// ---------------------------------------------------------------
	// whole accumulator compared; stray upper bits give no parcel
	function automatic sel_kind_t decode_sel(input logic [SEL_W-1:0] sel);
		sel_kind_t kind;
		kind = KIND_NONE;
		unique case (sel)
			SEL_XFER_COUNT: begin
				kind = KIND_XFER_COUNT;
			end
			SEL_TAG: begin
				kind = KIND_TAG;
			end
			SEL_BUSY: begin
				kind = KIND_BUSY;
			end
			SEL_DONE: begin
				kind = KIND_DONE;
			end
			SEL_ACK_PEND: begin
				kind = KIND_ACK_PEND;
			end
			default: begin
				kind = KIND_NONE;
			end
		endcase
		return kind;
	endfunction

	// anything outside the five selectors reads as unknown
	function automatic logic kind_known(input sel_kind_t kind);
		return kind != KIND_NONE;
	endfunction

	// ---------------------------------------------------------------
	// parcel forming functions
	// ---------------------------------------------------------------
	// tag lines low, bus gates above, upper byte forced to zero
	function automatic logic [PARCEL_W-1:0] form_tag(input status_src_t s);
		logic [PARCEL_W-1:0] w;
		w = PARCEL_ZERO;
		w[TAG_LIVE_W-1:0] = s.tags;
		w[TAG_BUS_A_BIT] = s.gate_bus_a;
		w[TAG_BUS_B_BIT] = s.gate_bus_b;
		return w;
	endfunction

	// unknown selectors fall back to an all-zero parcel
	function automatic logic [PARCEL_W-1:0] pick_parcel(
		input sel_kind_t kind,
		input logic [PARCEL_W-1:0] count_w,
		input logic [PARCEL_W-1:0] tag_w,
		input logic [PARCEL_W-1:0] busy_w,
		input logic [PARCEL_W-1:0] done_w,
		input logic [PARCEL_W-1:0] pend_w
	);
		logic [PARCEL_W-1:0] w;
		w = PARCEL_ZERO;
		unique case (kind)
			KIND_NONE: begin
				w = PARCEL_ZERO;
			end
			KIND_XFER_COUNT: begin
				w = count_w;
			end
			KIND_TAG: begin
				w = tag_w;
			end
			KIND_BUSY: begin
				w = busy_w;
			end
			KIND_DONE: begin
				w = done_w;
			end
			KIND_ACK_PEND: begin
				w = pend_w;
			end
		endcase
		return w;
	endfunction

	// ---------------------------------------------------------------
	// parcel forming
	// ---------------------------------------------------------------
	always_comb begin
		count_parcel = src.transfer_count;
	end

	always_comb begin
		tag_parcel = form_tag(src);
	end

	// spindle flags widened with zero fill
	spindle_parcel u_busy (
		.flags(src.spindle_busy),
		.parcel(busy_parcel)
	);

	spindle_parcel u_done (
		.flags(src.spindle_done),
		.parcel(done_parcel)
	);

	spindle_parcel u_pend (
		.flags(src.dma_ack_pending),
		.parcel(pend_parcel)
	);

	// ---------------------------------------------------------------
	// selector decode
	// ---------------------------------------------------------------
	always_comb begin
		kind_nxt = decode_sel(select_value);
		known_nxt = kind_known(kind_nxt);
	end

	always_comb begin
		parcel_nxt = pick_parcel(kind_nxt, count_parcel, tag_parcel, busy_parcel,
			done_parcel, pend_parcel);
	end

	// answer strobe follows every read, known selector or not
	always_comb begin
		valid_nxt = status_read_function;
	end

	// ---------------------------------------------------------------
	// answer registers
	// ---------------------------------------------------------------
	// sources are inputs only, so a read cannot disturb them
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			parcel_r <= PARCEL_ZERO;
		end else if (status_read_function) begin
			parcel_r <= parcel_nxt;
		end
	end

	// held until the next read, like the parcel
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			known_r <= 1'b0;
		end else if (status_read_function) begin
			known_r <= known_nxt;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			valid_r <= 1'b0;
		end else begin
			valid_r <= valid_nxt;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	// each output is a flop with no logic behind it
	assign status_parcel = parcel_r;
	assign status_valid = valid_r;
	assign select_known = known_r;

endmodule

// file: status_select_readback_props.sv
`timescale 1ns/1ps
module status_select_readback_props
	import status_select_pkg::*;
(
	input logic ref_clk,
	input logic rst,
	input logic status_read_function,
	input logic [SEL_W-1:0] select_value,
	input status_src_t src,
	input logic [PARCEL_W-1:0] status_parcel,
	input logic status_valid,
	input logic select_known
);
	wire r = status_read_function;
	wire [15:0] s = select_value;
	wire [15:0] p = status_parcel;
	status_src_t q;
	always_ff @(posedge ref_clk) q <= src;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_count_sel: assert property (r && s == 2 |=>
		p == q.transfer_count) else $error("count");
	a_tag_sel: assert property (r && s == 3 |=>
		p == {q.gate_bus_b, q.gate_bus_a, q.tags}) else $error("tag");
	a_busy_sel: assert property (r && s == 4 |=>
		p == q.spindle_busy) else $error("busy");
	a_done_sel: assert property (r && s == 5 |=>
		p == q.spindle_done) else $error("done");
	a_pend_sel: assert property (r && s == 6 |=>
		p == q.dma_ack_pending) else $error("pend");
	a_unknown_zero: assert property (r && !(s inside {[2:6]}) |=>
		p == 0 && !select_known) else $error("unknown");
	a_valid_answer: assert property (r |=> status_valid) else $error("valid");
	a_idle_hold: assert property (!r |=> $stable(p) && !status_valid) else $error("hold");
endmodule
bind status_select_readback status_select_readback_props status_select_readback_props_i (.*);

// file: status_host.sv
`timescale 1ns/1ps
module status_host (
	input logic ref_clk,
	output logic status_read_function = 1'b0,
	output logic [15:0] select_value = 16'h0000
);
	task automatic issue(input logic [15:0] s);
		@(posedge ref_clk);
		#1 {status_read_function, select_value} = {1'b1, s};
		@(posedge ref_clk);
		#1 {status_read_function, select_value} = {1'b0, ~s};
	endtask
endmodule

// file: status_select_readback_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module status_select_readback_tb_top;
	import status_select_pkg::*;
	logic ref_clk, rst, status_read_function, status_valid, select_known;
	logic [15:0] select_value, status_parcel;
	status_src_t src;
	int bad_count, cmp_count;
	status_select_readback status_select_readback_i (.*);
	status_host status_host_i (.*);
	task automatic ask(input logic [15:0] s, input logic [16:0] e);
		status_host_i.issue(s);
		`CHK("reply", {1'b1, e}, {status_valid, select_known, status_parcel})
	endtask
	task automatic t_fields();
		src.transfer_count = 16'ha5c3;
		ask(16'h0002, 17'h1_a5c3);
		src.tags = '0;
		src.tags.attention_in = 1'b1;
		ask(16'h0003, 17'h1_00e0);
		src.tags = '0;
		src.tags.select_out = 1'b1;
		src.gate_bus_b = 1'b0;
		ask(16'h0003, 17'h1_0041);
		$display("fields done");
	endtask
	task automatic t_spindles();
		src.spindle_busy = 5'h16;
		src.spindle_done = 5'h0a;
		src.dma_ack_pending = 5'h05;
		ask(16'h0004, 17'h1_0016);
		ask(16'h0005, 17'h1_000a);
		ask(16'h0006, 17'h1_0005);
		ask(16'h0007, 17'h0_0000);
		ask(16'h0102, 17'h0_0000);
		$display("spindles done");
	endtask
	task automatic t_reset();
		ask(16'h0004, 17'h1_0016);
		@(posedge ref_clk);
		#1;
		`CHK("hold", 18'h1_0016, {status_valid, select_known, status_parcel})
		rst = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
		`CHK("reset", 18'h0_0000, {status_valid, select_known, status_parcel})
		rst = 1'b0;
		ask(16'h0005, 17'h1_000a);
		$display("reset done");
	endtask
	initial begin
		ref_clk = 0;
		forever #2 ref_clk = ~ref_clk;
	end
	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#1000;
		bad_count++;
		summarize();
	end
	initial begin
		rst = 1;
		src = '1;
		repeat (4) @(posedge ref_clk);
		#1 rst = 0;
		t_fields();
		t_spindles();
		t_reset();
		summarize();
	end
endmodule
